// ==== pkg/apfh_pkg.sv ====
// Contract
// - Latching error clears only after shutdown, pin or bit, goes low then high.
// - Latching condition still present at shutdown release re-enters fault and sets status.
// - Resume after toggle only once the recovery timeout has elapsed.
// - Non-latching errors resume playback automatically when the condition clears.
// - Only clock errors among non-latching errors pull the fault output low.
// - Fault output is open-drain active low; receiver provides the pull-up.
// - Latching error holds fault low until toggle done and timeout passed.
// - Clock error pulls fault low; valid clocks release it at once, no timeout.
// - Over-voltage is non-latching, follows supply above threshold, fault not asserted.
// - Under-voltage is non-latching, clears when supply returns, fault not asserted.
// - Clock error on bad ratio, bad rate or any of three clocks stopped.
// - Over-current is latching, cleared by timeout plus shutdown toggle.
// - DC offset is latching, cleared by timeout plus shutdown toggle.
// - Over-temperature latching; also needs temperature below threshold minus hysteresis.
// - Every error is shown on fault pin as applicable and in status register.
// - Switching frequency is a selectable integer multiple of the sample rate.
// - Modulator makes two complementary PWM pairs, one per channel.
// - DC error when duty above 60 percent same polarity beyond 420 ms.
// - Shutdown low enters shutdown; high leaves it.
package apfh_pkg;
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned FAULT_RECOVERY_MS  = 1;
  localparam int unsigned FAULT_RECOVERY_CYC = CLK_HZ / 1000 * FAULT_RECOVERY_MS;
  localparam int unsigned DC_HOLD_MS         = 420;
  localparam int unsigned DC_HOLD_CYC        = CLK_HZ / 1000 * DC_HOLD_MS;
  localparam int unsigned DC_DUTY_PCT        = 60;
  localparam int unsigned PCT_SCALE          = 100;
  localparam int unsigned PWM_MULT_DEF       = 16;

  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_PWMCFG  = 8'h08;

  localparam int unsigned ST_OVERVOLT  = 0;
  localparam int unsigned ST_UNDERVOLT = 1;
  localparam int unsigned ST_CLOCK     = 2;
  localparam int unsigned ST_OVERCUR   = 3;
  localparam int unsigned ST_DCOFFSET  = 4;
  localparam int unsigned ST_OVERTEMP  = 5;
  localparam int unsigned ST_FAULTED   = 6;
  localparam int unsigned ST_PLAYING   = 7;
  localparam int unsigned CTL_SHUTDOWN = 0;
  localparam logic [31:0] CTL_RESET    = 32'h0000_0001;

  typedef enum logic [1:0] {APFH_RUN, APFH_LATCHED, APFH_WAIT_REL, APFH_RECOVER} apfh_state_e;
endpackage : apfh_pkg

// ==== src/apfh_fault_handler.sv ====
`timescale 1ns/1ns
`default_nettype none
// One channel's DC run detector: counts cycles of duty held past the band on one side.
module apfh_dc_detect
  import apfh_pkg::*;
#(
  parameter int unsigned PWM_W  = 8,
  parameter int unsigned DC_CYC = DC_HOLD_CYC
) (
  input  wire logic             pclk,     // Block clock
  input  wire logic             presetn,  // Async reset, active low
  input  wire logic             enable,   // Count only while playing
  input  wire logic [PWM_W-1:0] duty,     // Latched duty of this channel
  output logic                  dc_err    // Run has reached the hold time
);
  localparam int unsigned DCW     = $clog2(DC_CYC + 1);
  localparam int unsigned DUTY_HI = DC_DUTY_PCT * (2 ** PWM_W);
  localparam int unsigned DUTY_LO = (PCT_SCALE - DC_DUTY_PCT) * (2 ** PWM_W);

  logic [DCW-1:0] cnt_ff;
  logic           pol_ff;
  logic           above;
  logic           below;

  assign above  = duty * PCT_SCALE > DUTY_HI;
  assign below  = duty * PCT_SCALE < DUTY_LO;
  // Counting stops at the hold time, so the flag stays up until playback stops or the duty leaves its side of the band.
  assign dc_err = cnt_ff >= DCW'(DC_CYC);

  // A flip of polarity restarts the run, so an AC swing never adds up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      pol_ff <= 1'b0;
    end else if (!enable) begin
      cnt_ff <= '0;
    end else if (above || below) begin
      pol_ff <= above;
      if (pol_ff != above) begin
        cnt_ff <= DCW'(1);
      end else if (!dc_err) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end else begin
      cnt_ff <= '0;
    end
  end
endmodule : apfh_dc_detect

module apfh_fault_handler
  import apfh_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = FAULT_RECOVERY_CYC,
  parameter int unsigned DC_CYC       = DC_HOLD_CYC,
  parameter int unsigned PWM_W        = 8
) (
  input  wire logic             pclk,              // APB clock, 10 MHz
  input  wire logic             presetn,           // Async reset, active low
  input  wire logic             psel,              // APB select
  input  wire logic             penable,           // APB access phase
  input  wire logic             pwrite,            // APB write
  input  wire logic [7:0]       paddr,             // APB byte address
  input  wire logic [31:0]      pwdata,            // APB write data
  output logic      [31:0]      prdata,            // APB read data
  output logic                  pready,            // APB ready
  output logic                  pslverr,           // APB error, unmapped address
  input  wire logic             amp_shutdown_n,    // Shutdown pin, low = shutdown
  input  wire logic             overvoltage_err,   // Supply above OV threshold
  input  wire logic             undervoltage_err,  // Supply below UV threshold
  input  wire logic             bad_ratio,         // Unsupported clock ratio
  input  wire logic             bad_rate,          // Unsupported clock rate
  input  wire logic             clock_stopped,     // A clock has stopped
  input  wire logic             overcurrent_err,   // Output current above threshold
  input  wire logic             overtemp_err,      // Die above threshold
  input  wire logic             overtemp_hysteresis, // Die still above thr minus hyst
  input  wire logic             sample_tick,       // One pulse per audio sample
  input  wire logic [PWM_W-1:0] audio_l,           // Left sample, offset binary
  input  wire logic [PWM_W-1:0] audio_r,           // Right sample, offset binary
  output logic                  amp_fault_n_o,     // Fault pin output level, always 0
  output logic                  amp_fault_n_oe,    // Fault pin drive enable
  output logic                  playing,           // Power stage enabled
  output logic                  pwm_l_p,           // Left PWM
  output logic                  pwm_l_n,           // Left PWM complement
  output logic                  pwm_r_p,           // Right PWM
  output logic                  pwm_r_n            // Right PWM complement
);
  localparam int unsigned RCW = $clog2(RECOVERY_CYC + 1);

  apfh_state_e    state_ff;
  apfh_state_e    nxt_state;
  logic [31:0]    ctl_ff;
  logic [7:0]     pwm_mult_ff;
  logic [RCW-1:0] rec_cnt_ff;
  logic [2:0]     latched_ff;
  logic [7:0]     sub_cnt_ff;
  logic [PWM_W-1:0] ramp_ff;
  logic [PWM_W-1:0] duty_l_ff;
  logic [PWM_W-1:0] duty_r_ff;
  logic           pwm_l_ff;
  logic           pwm_r_ff;
  logic           dc_err_l;
  logic           dc_err_r;
  logic           dc_offset_err;
  logic           clock_err;
  logic           shutdown_n;
  logic           latch_now;
  logic           nonlatch_block;
  logic           wr_en;
  logic           rd_en;
  logic           addr_ok;
  logic           ot_hold;
  logic           rec_load;
  logic           rec_done;
  logic           fault_req;
  logic [31:0]    status_word;

  // Pin and control bit are ANDed, so either one low shuts the stage down.
  assign shutdown_n = amp_shutdown_n & ctl_ff[CTL_SHUTDOWN];
  assign clock_err = bad_ratio | bad_rate | clock_stopped;
  assign dc_offset_err = dc_err_l | dc_err_r;
  assign latch_now = overcurrent_err | dc_offset_err | overtemp_err;
  // Over-/under-voltage and clock errors only stall playback while present.
  assign nonlatch_block = overvoltage_err | undervoltage_err | clock_err;
  // Over-temperature keeps recovery waiting until the die cools past the hysteresis point.
  assign ot_hold = latched_ff[2] && overtemp_hysteresis;
  // The timer reloads on every fault entry, re-entry after a release included.
  assign rec_load = nxt_state == APFH_LATCHED && state_ff != APFH_LATCHED;
  assign rec_done = rec_cnt_ff == '0;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      APFH_RUN: begin
        // A cause during shutdown is ignored; one still present at release is picked up then.
        if (shutdown_n && latch_now) begin
          nxt_state = APFH_LATCHED;
        end
      end
      APFH_LATCHED: begin
        if (!shutdown_n) begin
          nxt_state = APFH_WAIT_REL;
        end
      end
      APFH_WAIT_REL: begin
        // A cause still present at release re-enters the fault and reloads the timer.
        if (shutdown_n) begin
          nxt_state = latch_now ? APFH_LATCHED : APFH_RECOVER;
        end
      end
      APFH_RECOVER: begin
        if (!shutdown_n) begin
          nxt_state = APFH_WAIT_REL;
        end else if (latch_now) begin
          nxt_state = APFH_LATCHED;
        end else if (rec_done && !ot_hold) begin
          nxt_state = APFH_RUN;
        end
      end
      default: nxt_state = APFH_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= APFH_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Timeout starts on fault entry and keeps running through the toggle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_ff <= '0;
    end else if (rec_load) begin
      rec_cnt_ff <= RCW'(RECOVERY_CYC);
    end else if (!rec_done) begin
      rec_cnt_ff <= rec_cnt_ff - 1'b1;
    end
  end

  // Latching status holds the cause; set wins, bits clear on leaving fault.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_ff <= '0;
    end else if (shutdown_n && latch_now) begin
      latched_ff <= latched_ff | {overtemp_err, dc_offset_err, overcurrent_err};
    end else if (state_ff == APFH_RECOVER && nxt_state == APFH_RUN) begin
      latched_ff <= '0;
    end
  end

  // Over-temperature lingers until the die cools past the hysteresis point.
  always_comb begin
    playing = shutdown_n && state_ff == APFH_RUN && !nonlatch_block && !latch_now
              && !ot_hold;
  end

  // Clock errors pull the pin at once; over- and under-voltage never do.
  assign fault_req = (state_ff != APFH_RUN) || (shutdown_n && latch_now)
                     || clock_err;

  // Registered so a combinational glitch of the causes never reaches the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_fault_n_oe <= 1'b0;
    end else begin
      amp_fault_n_oe <= fault_req;
    end
  end
  assign amp_fault_n_o = 1'b0;

  // DC detect runs per channel and feeds the latching cause set.
  apfh_dc_detect #(
    .PWM_W  (PWM_W),
    .DC_CYC (DC_CYC)
  ) u_dc_l (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (playing),
    .duty    (duty_l_ff),
    .dc_err  (dc_err_l)
  );

  apfh_dc_detect #(
    .PWM_W  (PWM_W),
    .DC_CYC (DC_CYC)
  ) u_dc_r (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (playing),
    .duty    (duty_r_ff),
    .dc_err  (dc_err_r)
  );

  // Duty is taken once per sample so a channel never changes level mid-ramp.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_l_ff <= '0;
      duty_r_ff <= '0;
    end else if (sample_tick) begin
      duty_l_ff <= audio_l;
      duty_r_ff <= audio_r;
    end
  end

  // PWM: each sample period is split into pwm_mult ramps, locked to the sample rate.
  // The ramp parks once the multiplier count is reached, until the next sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_ff    <= '0;
      sub_cnt_ff <= '0;
    end else if (sample_tick) begin
      ramp_ff    <= '0;
      sub_cnt_ff <= '0;
    end else if (ramp_ff == '1) begin
      ramp_ff <= '0;
      if (sub_cnt_ff != pwm_mult_ff) begin
        sub_cnt_ff <= sub_cnt_ff + 1'b1;
      end
    end else if (sub_cnt_ff != pwm_mult_ff) begin
      ramp_ff <= ramp_ff + 1'b1;
    end
  end

  // Both channels share one ramp so the pairs switch in step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_l_ff <= 1'b0;
    end else begin
      pwm_l_ff <= playing && (ramp_ff < duty_l_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_r_ff <= 1'b0;
    end else begin
      pwm_r_ff <= playing && (ramp_ff < duty_r_ff);
    end
  end
  // The n leg drops with playing and the registered p leg one cycle later, so the bridge idles rather than shorts.
  assign pwm_l_p = pwm_l_ff;
  assign pwm_l_n = playing & ~pwm_l_ff;
  assign pwm_r_p = pwm_r_ff;
  assign pwm_r_n = playing & ~pwm_r_ff;

  // APB slave: zero wait states, unmapped addresses return an error.
  assign addr_ok = paddr == ADDR_STATUS || paddr == ADDR_CONTROL || paddr == ADDR_PWMCFG;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Only the shutdown bit is kept; the other control bits read back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= CTL_RESET;
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      ctl_ff <= {31'h0000_0000, pwdata[CTL_SHUTDOWN]};
    end
  end

  // A multiplier of zero would park the ramp for good, so such writes are dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_mult_ff <= 8'(PWM_MULT_DEF);
    end else if (wr_en && paddr == ADDR_PWMCFG && pwdata[7:0] != 8'h00) begin
      pwm_mult_ff <= pwdata[7:0];
    end
  end

  // Status word: live non-latching errors, latched causes, then summary bits.
  always_comb begin
    status_word               = '0;
    status_word[ST_OVERVOLT]  = overvoltage_err;
    status_word[ST_UNDERVOLT] = undervoltage_err;
    status_word[ST_CLOCK]     = clock_err;
    status_word[ST_OVERCUR]   = latched_ff[0];
    status_word[ST_DCOFFSET]  = latched_ff[1];
    status_word[ST_OVERTEMP]  = latched_ff[2];
    status_word[ST_FAULTED]   = state_ff != APFH_RUN;
    status_word[ST_PLAYING]   = playing;
  end

  // Read data is loaded in the setup cycle, so the access phase needs no wait state.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      case (paddr)
        ADDR_STATUS:  prdata <= status_word;
        ADDR_CONTROL: prdata <= ctl_ff;
        ADDR_PWMCFG:  prdata <= {24'h00_0000, pwm_mult_ff};
        default:      prdata <= '0;
      endcase
    end
  end
endmodule : apfh_fault_handler
`default_nettype wire

// ==== bench/apfh_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module apfh_properties
  import apfh_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = FAULT_RECOVERY_CYC
) (
  input wire logic pclk, presetn, psel, penable, pready, pslverr,
  input wire logic amp_shutdown_n, overvoltage_err, undervoltage_err, overcurrent_err,
  input wire logic bad_ratio, bad_rate, clock_stopped, amp_fault_n_o, amp_fault_n_oe,
  input wire logic playing, pwm_l_p, pwm_l_n, pwm_r_p, pwm_r_n
);
  localparam int unsigned RC_MIN = RECOVERY_CYC - 2;
  logic        clk_err;
  logic [31:0] hi_cnt_ff;
  logic        clk_seen_ff;
  assign clk_err = bad_ratio | bad_rate | clock_stopped;
  // Clock faults release with no timeout, so a low run touched by one is not timed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff   <= 32'h0;
      clk_seen_ff <= 1'b0;
    end else begin
      hi_cnt_ff   <= amp_fault_n_oe ? hi_cnt_ff + 32'h1 : 32'h0;
      clk_seen_ff <= clk_err | (amp_fault_n_oe & clk_seen_ff);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  drive_low_a: assert property (amp_fault_n_o == 1'b0)
    else $error("fault pin driven high");
  clk_fault_a: assert property (clk_err |=> amp_fault_n_oe)
    else $error("clock error without fault pin");
  supply_stop_a: assert property (overvoltage_err || undervoltage_err |-> !playing)
    else $error("playing during supply error");
  sd_stop_a: assert property (!amp_shutdown_n |-> !playing)
    else $error("playing in shutdown");
  fault_entry_a: assert property ($rose(amp_fault_n_oe) |-> !playing)
    else $error("playing as fault asserts");
  pwm_pairs_a: assert property (pwm_l_n == (playing & ~pwm_l_p) && pwm_r_n == (playing & ~pwm_r_p))
    else $error("pwm pair not complementary");
  apb_err_a: assert property (pready && (!pslverr || (psel && penable)))
    else $error("bus answer outside access");
  oc_latch_a: assert property (overcurrent_err && amp_shutdown_n |-> ##2 amp_fault_n_oe)
    else $error("overcurrent not latched");
  recover_time_a: assert property ($fell(amp_fault_n_oe) && !clk_seen_ff |-> hi_cnt_ff >= RC_MIN)
    else $error("fault released before timeout");
endmodule : apfh_properties
bind apfh_fault_handler apfh_properties #(.RECOVERY_CYC(RECOVERY_CYC)) u_props (.*);
`default_nettype wire

// ==== bench/apfh_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module apfh_host_model (
  input  wire logic amp_fault_n_o,  // Level the block drives
  input  wire logic amp_fault_n_oe, // Block pulls the line
  input  wire logic sd_cmd,         // Host shutdown request, low = shutdown
  input  wire logic tie_fault,      // Loop the fault line into shutdown
  output logic      fault_wire,     // Resolved fault line
  output logic      amp_shutdown_n  // Shutdown pin to the block
);
  // The host keeps a pull-up, so a released line reads high, not the last driven level.
  assign fault_wire     = amp_fault_n_oe ? amp_fault_n_o : 1'b1;
  assign amp_shutdown_n = sd_cmd & (tie_fault ? fault_wire : 1'b1);
endmodule : apfh_host_model
`default_nettype wire

// ==== bench/tb_amp_protection_fault_handler.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_amp_protection_fault_handler;
  import apfh_pkg::*;
  localparam int RC = 20;
  localparam int DC = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sd_cmd, dc_on, sample_tick;
  logic overvoltage_err, undervoltage_err, bad_ratio, bad_rate, clock_stopped;
  logic overcurrent_err, overtemp_err, overtemp_hysteresis, amp_fault_n_o, amp_fault_n_oe;
  logic fault_wire, amp_shutdown_n, playing, pwm_l_p, pwm_l_n, pwm_r_p, pwm_r_n;
  logic [1:0]  tick_cnt;
  logic [7:0]  paddr, audio_l, audio_r;
  logic [31:0] pwdata, prdata, seed, r;
  logic [32:0] exp_q[$];
  int mismatches, check_count;
  apfh_fault_handler #(.RECOVERY_CYC(RC), .DC_CYC(DC)) DUT (.*);
  apfh_host_model u_host (.amp_fault_n_o(amp_fault_n_o), .amp_fault_n_oe(amp_fault_n_oe),
    .sd_cmd(sd_cmd), .tie_fault(1'b0), .fault_wire(fault_wire), .amp_shutdown_n(amp_shutdown_n));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // Reads queue their expected word; the monitor below does the comparing.
  task automatic apb(input logic [7:0] a, input logic w, input logic [32:0] d);
    int n;
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin mismatches++; complete_run(); end
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic see(input logic [1:0] exp);
    @(negedge pclk);
    chk({31'h0, fault_wire, playing}, {31'h0, exp});
  endtask : see
  task automatic wait_pin(input logic v, input int lim);
    int n;
    n = 0;
    while (fault_wire !== v && n < lim) begin @(negedge pclk); n++; end
    if (n >= lim) begin mismatches++; complete_run(); end
    @(posedge pclk);
  endtask : wait_pin
  task automatic tog();
    @(posedge pclk); sd_cmd <= 1'b0;
    cyc(3); sd_cmd <= 1'b1;
  endtask : tog
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1_FFFF_FFFF);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  // Random mid-scale audio keeps the duty inside the band; dc_on forces the left channel to full scale.
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= (tick_cnt == 2'h0);
    audio_l <= dc_on ? 8'hFF : 8'h69 + 8'(xs() % 47);
    audio_r <= 8'h69 + 8'(xs() % 47);
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    seed = 32'h79D6EE05; presetn = 1'b0; tick_cnt = 2'h0; sample_tick = 1'b0; dc_on = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, audio_l, audio_r} = '0;
    {overvoltage_err, undervoltage_err, bad_ratio, bad_rate, clock_stopped} = '0;
    {overcurrent_err, overtemp_err, overtemp_hysteresis} = '0;
    sd_cmd = 1'b1;
    cyc(10); presetn <= 1'b1;
    apb(ADDR_STATUS, 1'b0, 33'h80);
    apb(ADDR_CONTROL, 1'b0, 33'h1);
    apb(8'h0C, 1'b0, 33'h1_0000_0000);
    apb(ADDR_PWMCFG, 1'b1, 33'h0);
    apb(ADDR_PWMCFG, 1'b0, 33'h10);
    r = (xs() % 15) + 1;
    apb(ADDR_PWMCFG, 1'b1, {1'b0, r});
    apb(ADDR_PWMCFG, 1'b0, {1'b0, r});
    $display("registers done");
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk); overvoltage_err <= (i == 0); undervoltage_err <= (i == 1);
      cyc(3); see(2'b10);
      apb(ADDR_STATUS, 1'b0, 33'h1 << i);
      @(posedge pclk); overvoltage_err <= 1'b0; undervoltage_err <= 1'b0;
      cyc(3); see(2'b11);
    end
    $display("supply errors done");
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk); {bad_ratio, bad_rate, clock_stopped} <= 3'h4 >> i;
      cyc(3); see(2'b00);
      apb(ADDR_STATUS, 1'b0, 33'h4);
      @(posedge pclk); {bad_ratio, bad_rate, clock_stopped} <= 3'h0;
      cyc(2); see(2'b11);
    end
    $display("clock errors done");
    @(posedge pclk); overcurrent_err <= 1'b1;
    cyc(2); overcurrent_err <= 1'b0;
    wait_pin(1'b0, 10);
    cyc(RC + 10); see(2'b00);
    apb(ADDR_STATUS, 1'b0, 33'h48);
    tog(); wait_pin(1'b1, 10); see(2'b11);
    apb(ADDR_STATUS, 1'b0, 33'h80);
    $display("overcurrent done");
    @(posedge pclk); overcurrent_err <= 1'b1;
    wait_pin(1'b0, 10);
    tog(); cyc(3); see(2'b00);
    apb(ADDR_STATUS, 1'b0, 33'h48);
    @(posedge pclk); overcurrent_err <= 1'b0;
    tog(); cyc(RC / 4); see(2'b00);
    wait_pin(1'b1, RC + 10); see(2'b11);
    $display("reentry done");
    @(posedge pclk); dc_on <= 1'b1;
    wait_pin(1'b0, DC + 40); dc_on <= 1'b0;
    apb(ADDR_STATUS, 1'b0, 33'h50);
    apb(ADDR_CONTROL, 1'b1, 33'h0);
    apb(ADDR_CONTROL, 1'b1, 33'h1);
    wait_pin(1'b1, RC + 10); see(2'b11);
    $display("dc offset done");
    @(posedge pclk); overtemp_err <= 1'b1; overtemp_hysteresis <= 1'b1;
    wait_pin(1'b0, 10); overtemp_err <= 1'b0;
    cyc(RC); tog(); cyc(RC + 5);
    @(negedge pclk); chk({32'h0, playing}, 33'h0);
    @(posedge pclk); overtemp_hysteresis <= 1'b0;
    wait_pin(1'b1, RC + 10); see(2'b11);
    $display("overtemp done");
    complete_run();
  end
endmodule : tb_amp_protection_fault_handler
`default_nettype wire
